// *** rtl/mpcd_top.v ***
/*
 multiphase clock divider: master clock, programmable divider by
 1, 10 or 100, 2-, 3- or 4-phase generator, spreading code source.
 assumes select pins arrive synchronous to CLK_SYS as 2-bit codes
 (low, float, high); CLK_SYS stands for the master oscillator, one
 cycle per master half period.
*/
`timescale 1ns/10ps
`include "mpcd_consts.vh"

module mpcd_top #(
    parameter SPREAD_SPECTRUM_MODULATION_STEP_CYCLES = `MPCD_SPREAD_SPECTRUM_MODULATION_STEP_CYC,
    parameter DIV_W = `MPCD_DIV_W
) (
    // clock and reset
    input wire CLK_SYS,
    input wire SYS_RST,
    // mode select pins
    input wire [1:0] DIVIDER_SELECT_PIN,
    input wire [1:0] PHASE_SELECT_PIN,
    // spreading enable, low when grounded
    input wire MODULATION_PIN,
    // phase outputs
    output reg PHASE_OUTPUT_A,
    output reg PHASE_OUTPUT_B,
    output reg PHASE_OUTPUT_C,
    output reg PHASE_OUTPUT_D,
    // spreading code and state
    output wire [`MPCD_CODE_W-1:0] SPREAD_CODE,
    output reg SPREAD_ACTIVE
);
    // phase modes
    localparam [1:0] MODE_2PH = 2'h0;
    localparam [1:0] MODE_3PH = 2'h1;
    localparam [1:0] MODE_4PH = 2'h2;

    // divider terminal count for a select code
    function [DIV_W-1:0] div_last;
        input [1:0] sel;
        begin
            case (sel)
                `MPCD_PIN_LOW: div_last = `MPCD_N1_LAST;
                `MPCD_PIN_HIGH: div_last = `MPCD_N100_LAST;
                default: div_last = `MPCD_N10_LAST;
            endcase
        end
    endfunction

    // phase mode for a select code
    function [1:0] ph_mode;
        input [1:0] sel;
        begin
            case (sel)
                `MPCD_PIN_LOW: ph_mode = MODE_2PH;
                `MPCD_PIN_HIGH: ph_mode = MODE_4PH;
                default: ph_mode = MODE_3PH;
            endcase
        end
    endfunction

    // start pattern for a phase mode, order {d,c,b,a}
    function [3:0] pat_start;
        input [1:0] mode;
        begin
            case (mode)
                MODE_2PH: pat_start = `MPCD_PAT2_START;
                MODE_3PH: pat_start = `MPCD_PAT3_START;
                MODE_4PH: pat_start = `MPCD_PAT4_START;
                default: pat_start = `MPCD_PAT_RESET;
            endcase
        end
    endfunction

    // two-phase step: a toggles, b its inverse, c and d copies
    function [3:0] pat2_next;
        input [3:0] p;
        begin
            pat2_next[0] = ~p[0];
            pat2_next[1] = p[0];
            pat2_next[2] = ~p[0];
            pat2_next[3] = p[0];
        end
    endfunction

    // three-phase step: one-hot ring a, b, c, d parked low
    function [3:0] pat3_next;
        input [3:0] p;
        begin
            pat3_next[0] = p[2];
            pat3_next[1] = p[0];
            pat3_next[2] = p[1];
            pat3_next[3] = 1'b0;
        end
    endfunction

    // four-phase step: twisted ring, each an eighth of a period behind
    function [3:0] pat4_next;
        input [3:0] p;
        begin
            pat4_next[0] = ~p[3];
            pat4_next[1] = p[0];
            pat4_next[2] = p[1];
            pat4_next[3] = p[2];
        end
    endfunction

    reg init_ff;
    reg [1:0] div_sel_ff;
    reg [1:0] ph_sel_ff;
    reg [DIV_W-1:0] cnt_ff;
    reg half_ff;
    reg [1:0] mode_ff;

    reg restart;
    reg tick;
    reg step;
    reg [1:0] nxt_mode;
    reg [DIV_W-1:0] nxt_cnt;
    reg nxt_half;
    reg [3:0] pat;
    reg [3:0] nxt_pat;

    // a select change restarts divider and phase pattern cleanly
    always @* begin
        restart = init_ff || (DIVIDER_SELECT_PIN != div_sel_ff) ||
                  (PHASE_SELECT_PIN != ph_sel_ff);
        nxt_mode = ph_mode(PHASE_SELECT_PIN);
    end

    // programmable divider, fed by the master clock
    always @* begin
        tick = 1'b0;
        nxt_cnt = cnt_ff;
        if (restart) begin
            nxt_cnt = {DIV_W{1'b0}};
        end else if (cnt_ff == div_last(div_sel_ff)) begin
            tick = 1'b1;
            nxt_cnt = {DIV_W{1'b0}};
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    // 3-phase steps on every second divider tick
    always @* begin
        step = 1'b0;
        nxt_half = half_ff;
        if (restart) begin
            nxt_half = 1'b0;
        end else if (tick) begin
            nxt_half = ~half_ff;
            if (mode_ff == MODE_3PH) begin
                step = half_ff;
            end else begin
                step = 1'b1;
            end
        end
    end

    // multiphase generator, pattern order {d,c,b,a}
    always @* begin
        pat = {PHASE_OUTPUT_D, PHASE_OUTPUT_C, PHASE_OUTPUT_B,
               PHASE_OUTPUT_A};
        nxt_pat = pat;
        if (restart) begin
            nxt_pat = pat_start(nxt_mode);
        end else if (step) begin
            case (mode_ff)
                MODE_2PH: begin
                    // b is a inverted; c and d copy a and b
                    nxt_pat = pat2_next(pat);
                end
                MODE_3PH: begin
                    // one-hot ring, d parked low
                    nxt_pat = pat3_next(pat);
                end
                MODE_4PH: begin
                    // twisted ring, each output an eighth of a period behind
                    nxt_pat = pat4_next(pat);
                end
                default: begin
                    nxt_pat = `MPCD_PAT_RESET;
                end
            endcase
        end
    end

    // all state moves on the clock edge; reset acts at once
    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            init_ff <= 1'b1;
            div_sel_ff <= `MPCD_PIN_FLOAT;
            ph_sel_ff <= `MPCD_PIN_FLOAT;
            cnt_ff <= {DIV_W{1'b0}};
            half_ff <= 1'b0;
            mode_ff <= MODE_3PH;
            PHASE_OUTPUT_A <= 1'b0;
            PHASE_OUTPUT_B <= 1'b0;
            PHASE_OUTPUT_C <= 1'b0;
            PHASE_OUTPUT_D <= 1'b0;
            SPREAD_ACTIVE <= 1'b0;
        end else begin
            init_ff <= 1'b0;
            div_sel_ff <= DIVIDER_SELECT_PIN;
            ph_sel_ff <= PHASE_SELECT_PIN;
            cnt_ff <= nxt_cnt;
            half_ff <= nxt_half;
            mode_ff <= nxt_mode;
            // registered outputs, no glitch between edges
            PHASE_OUTPUT_A <= nxt_pat[0];
            PHASE_OUTPUT_B <= nxt_pat[1];
            PHASE_OUTPUT_C <= nxt_pat[2];
            PHASE_OUTPUT_D <= nxt_pat[3];
            // grounded pin turns spreading off
            SPREAD_ACTIVE <= MODULATION_PIN;
        end
    end

    // spreading code source; steps once per SPREAD_SPECTRUM_MODULATION_STEP_CYCLES CLK_SYS cycles, rate scales with the master clock
    mpcd_prbs #(
        .STEP_CYCLES(SPREAD_SPECTRUM_MODULATION_STEP_CYCLES),
        .PRE_W(`MPCD_PRE_W)
    ) u_prbs (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .enable(SPREAD_ACTIVE),
        .code_ff(SPREAD_CODE)
    );
endmodule

// *** rtl/mpcd_consts.vh ***
/*
 constants for the multiphase clock divider: pin encodings, divider
 terminal counts, phase patterns, modulation generator figures.
 assumes the including file compiles it once per unit; guarded.
*/
`ifndef MPCD_CONSTS_VH
`define MPCD_CONSTS_VH

// clock
`define MPCD_CLK_HZ 10000000
// system cycles per master oscillator period (one per half period)
`define MPCD_CYC_PER_MASTER 2

// three-state pin encodings
`define MPCD_PIN_LOW 2'h0
`define MPCD_PIN_FLOAT 2'h1
`define MPCD_PIN_HIGH 2'h2

// divider terminal counts, ratio minus one, in half master periods
`define MPCD_DIV_W 7
`define MPCD_N1_LAST 7'h00
`define MPCD_N10_LAST 7'h09
`define MPCD_N100_LAST 7'h63

// phase start patterns, order {d,c,b,a}
`define MPCD_PAT2_START 4'hA
`define MPCD_PAT3_START 4'h1
`define MPCD_PAT4_START 4'h0
`define MPCD_PAT_RESET 4'h0

// modulation generator
`define MPCD_SPREAD_SPECTRUM_MODULATION_DIV 3200
`define MPCD_SPREAD_SPECTRUM_MODULATION_STEP_CYC (`MPCD_SPREAD_SPECTRUM_MODULATION_DIV * `MPCD_CYC_PER_MASTER)
`define MPCD_PRE_W 16
`define MPCD_LFSR_W 9
`define MPCD_CODE_W 7
`define MPCD_LFSR_SEED 9'h000
`define MPCD_LFSR_TAP_HI 8
`define MPCD_LFSR_TAP_LO 4
`define MPCD_CODE_RESET 7'h00

`endif

// *** rtl/mpcd_prbs.v ***
/*
 modulation code generator: prescaled 9-bit feedback shift register
 with the all-zero state spliced in, low bits as the converter code.
 assumes a single clock and an enable held low when spreading is off.
*/
`timescale 1ns/10ps
`include "mpcd_consts.vh"

module mpcd_prbs #(
    parameter STEP_CYCLES = `MPCD_SPREAD_SPECTRUM_MODULATION_STEP_CYC,
    parameter PRE_W = `MPCD_PRE_W
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire enable,
    // code to the modulation converter
    output reg [`MPCD_CODE_W-1:0] code_ff
);
    localparam [31:0] PRE_LAST32 = STEP_CYCLES - 1;

    reg [PRE_W-1:0] pre_ff;
    reg [`MPCD_LFSR_W-1:0] lfsr_ff;
    reg [PRE_W-1:0] nxt_pre;
    reg [`MPCD_LFSR_W-1:0] nxt_lfsr;
    reg [`MPCD_CODE_W-1:0] nxt_code;
    reg fb;
    reg step;

    always @* begin
        fb = 1'b0;
        step = 1'b0;
        nxt_pre = pre_ff;
        nxt_lfsr = lfsr_ff;
        nxt_code = code_ff;
        if (!enable) begin
            // zero code means no subtraction: frequency at its top
            nxt_pre = {PRE_W{1'b0}};
            nxt_code = `MPCD_CODE_RESET;
        end else begin
            step = (pre_ff == PRE_LAST32[PRE_W-1:0]);
            if (step) begin
                nxt_pre = {PRE_W{1'b0}};
            end else begin
                nxt_pre = pre_ff + 1'b1;
            end
            // zero splice gives the full 512-state cycle
            fb = lfsr_ff[`MPCD_LFSR_TAP_HI] ^ lfsr_ff[`MPCD_LFSR_TAP_LO] ^
                 (lfsr_ff[`MPCD_LFSR_W-2:0] == 8'h00);
            if (step) begin
                nxt_lfsr = {lfsr_ff[`MPCD_LFSR_W-2:0], fb};
                nxt_code = nxt_lfsr[`MPCD_CODE_W-1:0];
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_ff <= {PRE_W{1'b0}};
            lfsr_ff <= `MPCD_LFSR_SEED;
            code_ff <= `MPCD_CODE_RESET;
        end else begin
            pre_ff <= nxt_pre;
            lfsr_ff <= nxt_lfsr;
            code_ff <= nxt_code;
        end
    end
endmodule

// *** verification/mpcd_top_asserts.sv ***
/*
 checker for the phase outputs and the spreading code.
 assumes it is bound into mpcd_top, one clock domain.
*/
`timescale 1ns/10ps
module mpcd_top_chk #(
    parameter SPREAD_SPECTRUM_MODULATION_STEP_CYCLES = 8,
    parameter DIV_W = 7
) (
    input wire CLK_SYS,
    input wire SYS_RST,
    input wire [1:0] DIVIDER_SELECT_PIN,
    input wire [1:0] PHASE_SELECT_PIN,
    input wire MODULATION_PIN,
    input wire PHASE_OUTPUT_A,
    input wire PHASE_OUTPUT_B,
    input wire PHASE_OUTPUT_C,
    input wire PHASE_OUTPUT_D,
    input wire [6:0] SPREAD_CODE,
    input wire SPREAD_ACTIVE
);
    reg [3:0] sel_ff;
    reg chg_ff;
    reg [1:0] run_ff;
    reg [7:0] hi_ff;
    wire chg;
    wire [1:0] dv;
    wire [1:0] ph;
    assign dv = DIVIDER_SELECT_PIN;
    assign ph = PHASE_SELECT_PIN;
    assign chg = {dv, ph} != sel_ff;
    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            sel_ff <= 4'h0;
            chg_ff <= 1'b1;
            run_ff <= 2'h0;
            hi_ff <= 8'h00;
        end else begin
            sel_ff <= {dv, ph};
            chg_ff <= chg;
            run_ff <= {run_ff[0], 1'b1};
            hi_ff <= PHASE_OUTPUT_A ? hi_ff + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    // first edge after reset still shows reset values; skip the first two
    default disable iff (SYS_RST || chg || chg_ff || !run_ff[1]);
    sequence s_high_ten;
        PHASE_OUTPUT_A [*8] ##1 PHASE_OUTPUT_A ##1 !PHASE_OUTPUT_A;
    endsequence
    sequence s_high_two;
        PHASE_OUTPUT_A ##1 !PHASE_OUTPUT_A;
    endsequence
    chk_two_inverted: assert property (ph == 2'h0 |->
        (PHASE_OUTPUT_B == !PHASE_OUTPUT_A) && (PHASE_OUTPUT_C ==
        PHASE_OUTPUT_A) && (PHASE_OUTPUT_D == PHASE_OUTPUT_B))
        else $error("two phase relation broken");
    chk_three_onehot: assert property (ph[0] |->
        !PHASE_OUTPUT_D && $onehot({PHASE_OUTPUT_C, PHASE_OUTPUT_B,
        PHASE_OUTPUT_A})) else $error("three phase pattern broken");
    chk_four_ring: assert property (ph == 2'h2 &&
        $changed({PHASE_OUTPUT_A, PHASE_OUTPUT_B, PHASE_OUTPUT_C})
        |-> PHASE_OUTPUT_B == $past(PHASE_OUTPUT_A) &&
        PHASE_OUTPUT_C == $past(PHASE_OUTPUT_B) &&
        PHASE_OUTPUT_A == !$past(PHASE_OUTPUT_D))
        else $error("four phase ring broken");
    chk_div_one: assert property (ph == 2'h0 && dv == 2'h0
        |=> PHASE_OUTPUT_A != $past(PHASE_OUTPUT_A))
        else $error("divide by one rate wrong");
    chk_div_ten: assert property (ph == 2'h0 && dv == 2'h1 &&
        $rose(PHASE_OUTPUT_A) |=> s_high_ten)
        else $error("divide by ten rate wrong");
    chk_div_hundred: assert property (ph == 2'h0 &&
        dv == 2'h2 && $fell(PHASE_OUTPUT_A) |-> hi_ff == 8'h64)
        else $error("divide by hundred rate wrong");
    chk_three_rate: assert property (ph[0] && dv == 2'h0 &&
        $rose(PHASE_OUTPUT_A) |=> s_high_two)
        else $error("three phase duty wrong");
    chk_spread_off: assert property (!MODULATION_PIN |=>
        !SPREAD_ACTIVE ##1 SPREAD_CODE == 7'h00)
        else $error("spreading not shut off");
endmodule

bind mpcd_top mpcd_top_chk #(
    .SPREAD_SPECTRUM_MODULATION_STEP_CYCLES(SPREAD_SPECTRUM_MODULATION_STEP_CYCLES), .DIV_W(DIV_W)
) u_chk (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .DIVIDER_SELECT_PIN(DIVIDER_SELECT_PIN),
    .PHASE_SELECT_PIN(PHASE_SELECT_PIN), .MODULATION_PIN(MODULATION_PIN),
    .PHASE_OUTPUT_A(PHASE_OUTPUT_A), .PHASE_OUTPUT_B(PHASE_OUTPUT_B),
    .PHASE_OUTPUT_C(PHASE_OUTPUT_C), .PHASE_OUTPUT_D(PHASE_OUTPUT_D),
    .SPREAD_CODE(SPREAD_CODE), .SPREAD_ACTIVE(SPREAD_ACTIVE)
);

// *** verification/mpcd_load.sv ***
/*
 load sampling the phase outputs on clk: counts rising edges per phase.
 assumes outputs are sampled on the system clock.
*/
`timescale 1ns/10ps
module mpcd_load (
    // clock and control
    input wire clk,
    input wire clr,
    input wire spread_en,
    // phase outputs, d c b a
    input wire [3:0] phase,
    // modulation pin and edge counts
    output wire mod_pin,
    output reg [63:0] cnt
);
    reg [3:0] last_ff;
    integer j;
    // grounded unless spreading wanted
    assign mod_pin = spread_en;
    always @(posedge clk) begin
        last_ff <= phase;
        for (j = 0; j < 4; j = j + 1) begin
            if (clr)
                cnt[16*j +: 16] <= 16'h0000;
            else if (phase[j] && !last_ff[j])
                cnt[16*j +: 16] <= cnt[16*j +: 16] + 16'h0001;
        end
    end
endmodule

// *** verification/testbench.sv ***
/*
 testbench: all divider and phase modes, random modes, spreading code.
 assumes the load model counts edges over a whole number of periods.
*/
`timescale 1ns/10ps
`include "mpcd_consts.vh"
module testbench;
    reg clk_sys, sys_rst, spread_en, clr;
    reg [1:0] div_sel, ph_sel;
    wire [3:0] phase;
    wire mod_pin, spread_act;
    wire [`MPCD_CODE_W-1:0] code;
    wire [63:0] cnt;
    integer fail_count, checked, i, k;
    reg [31:0] lf;
    reg [8:0] st;
    mpcd_top #(.SPREAD_SPECTRUM_MODULATION_STEP_CYCLES(8)) dut (.CLK_SYS(clk_sys),
        .SYS_RST(sys_rst), .DIVIDER_SELECT_PIN(div_sel),
        .PHASE_SELECT_PIN(ph_sel), .MODULATION_PIN(mod_pin),
        .PHASE_OUTPUT_A(phase[0]), .PHASE_OUTPUT_B(phase[1]),
        .PHASE_OUTPUT_C(phase[2]), .PHASE_OUTPUT_D(phase[3]),
        .SPREAD_CODE(code), .SPREAD_ACTIVE(spread_act));
    mpcd_load u_load (.clk(clk_sys), .clr(clr), .spread_en(spread_en),
        .phase(phase), .mod_pin(mod_pin), .cnt(cnt));
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // advised divider for f_out times M in kHz: jitter or accuracy use
    function [15:0] adv_div(input integer fm, input integer acc);
        if (acc != 0)
            adv_div = (fm > 500) ? 16'h0001 :
                (fm >= 50) ? 16'h000A : 16'h0064;
        else
            adv_div = (fm >= 2000) ? 16'h0001 :
                (fm >= 200) ? 16'h000A : 16'h0064;
    endfunction
    task check(input [15:0] seen, input [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // two periods of the expected output, edges counted per phase
    task run_mode(input [1:0] dv, input [1:0] ph);
        integer n, m, f;
        n = (dv == 2'h0) ? 1 : (dv == 2'h2) ? 100 : 10;
        m = (ph == 2'h0) ? 2 : (ph == 2'h2) ? 8 : 6;
        f = `MPCD_CLK_HZ / `MPCD_CYC_PER_MASTER / 1000 / n;
        check(adv_div(f, 0), n[15:0]);
        if (n < 100)
            check(adv_div(f, 1), n[15:0]);
        div_sel = dv;
        ph_sel = ph;
        tick(3 + n * m);
        clr = 1;
        tick(1);
        clr = 0;
        tick(2 * n * m);
        check(cnt[15:0], 16'h0002);
        check(cnt[31:16], 16'h0002);
        check(cnt[47:32], 16'h0002);
        check(cnt[63:48], (m == 6) ? 16'h0000 : 16'h0002);
    endtask
    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #6000000;
        fail_count = fail_count + 1;
        end_sim;
    end
    initial begin
        fail_count = 0;
        checked = 0;
        lf = 32'h5c94;
        st = 9'h000;
        sys_rst = 1;
        spread_en = 0;
        clr = 0;
        div_sel = 2'h0;
        ph_sel = 2'h0;
        tick(12);
        sys_rst = 0;
        for (i = 0; i < 9; i = i + 1)
            run_mode(2'(i % 3), 2'(i / 3));
        for (i = 0; i < 4; i = i + 1) begin
            lf = lfsr(lf);
            run_mode(lf[1:0], lf[3:2]);
        end
        spread_en = 1;
        tick(2);
        check(spread_act, 16'h0001);
        for (i = 0; i < 6; i = i + 1) begin
            if (i == 3) begin
                spread_en = 0;
                tick(3);
                check(code, 16'h0000);
                spread_en = 1;
            end
            st = {st[7:0], st[8] ^ st[4] ^ (st[7:0] == 8'h00)};
            k = 0;
            while (code !== st[6:0] && k < 30) begin
                tick(1);
                k = k + 1;
            end
            check(code, st[6:0]);
        end
        end_sim;
    end
endmodule
